// *** hw/wkc_wake_csr.sv ***
// Summary of operation
// - writing one to bit 31 sends the filter pointer back to entry 0 and the bit always reads back as zero.
// - the filter is 40 words reached through one port whose pointer steps per access and wraps after the last.
// - with bit 9 set a valid global unicast frame counts as a filter wake qualifier.
// - a frame is global unicast when bit 0 of its destination address is zero.
// - the unicast qualifier wakes only while the filter wake enable in bit 2 is also set.
// - with bit 8 set all wake detection waits for the sleep state, with it clear detection runs at once.
// - bit 7 latches a valid frame matching the own station address until software writes one to it.
// - bit 6 latches a valid frame matching the filter until software writes one to it.
// - bit 5 latches a valid magic pattern frame until software writes one to it.
// - bit 4 latches a valid broadcast frame until software writes one to it.
// - bit 3 lets a frame matching the station address wake the device.
// - bit 2 lets a frame matching the programmed filter wake the device.
// - bit 1 lets a magic pattern frame wake the device and only then.
// - bit 0 lets a broadcast frame wake the device and only then.
`timescale 1ns/100ps
`include "wkc_defines.svh"
module wkc_wake_csr
  import wkc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // avalon-mm slave
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  // receive path frame indications
  input wire logic RX_FRAME_VALID,
  input wire logic RX_DEST_ADDR_BIT0,
  input wire logic RX_BROADCAST,
  input wire logic RX_MAGIC_MATCH,
  input wire logic RX_FILTER_MATCH,
  input wire logic RX_OWN_ADDR_MATCH,
  // power state
  input wire logic SLEEP_STATE,
  // wake and interrupt
  output logic WAKE_REQUEST,
  output logic DETECT_ACTIVE,
  output logic IRQ
);
  wkc_bus_state_t bus_state;
  wkc_bus_state_t next_bus_state;
  logic req;
  logic take;
  logic sel_filter;
  logic sel_csr;
  logic sel_mask;
  logic wr_take;
  logic rd_take;
  logic csr_lane0_wr;
  logic csr_lane1_wr;
  logic csr_lane3_wr;
  logic mask_wr;
  logic filter_wr;
  logic filter_step;

  wkc_ptr_t ptr;
  wkc_ptr_t next_ptr;
  wkc_word_t filter_rd_data;

  wkc_evt_t enables;
  wkc_evt_t flags;
  wkc_evt_t mask;
  wkc_evt_t hit;
  wkc_evt_t flag_clear;
  logic global_unicast_wake_qualifier;
  logic wait_sleep;
  logic ptr_rst;
  logic active;
  logic global_unicast;
  logic filter_hit;
  wkc_word_t csr_view;
  wkc_word_t mask_view;
  wkc_word_t next_readdata;

  // bus decode
  assign req = READ || WRITE;
  assign sel_filter = (ADDRESS == {`WKC_IDX_FILTER_PORT, 2'b00});
  assign sel_csr = (ADDRESS == {`WKC_IDX_WAKE_CSR, 2'b00});
  assign sel_mask = (ADDRESS == {`WKC_IDX_IRQ_MASK, 2'b00});

  // one wait cycle: request seen in idle, answered in the next cycle
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      bus_state <= BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      WAITREQUEST <= 1'b1;
    end else begin
      WAITREQUEST <= !(bus_state == BUS_IDLE && req);
    end
  end

  // effects land only on the edge the master sees waitrequest low
  assign take = (bus_state == BUS_ANSWER) && req;
  assign wr_take = take && WRITE;
  assign rd_take = take && READ;

  // per-lane write strobes, all qualified by the answer edge
  assign csr_lane0_wr = wr_take && sel_csr && BYTEENABLE[0];
  assign csr_lane1_wr = wr_take && sel_csr && BYTEENABLE[1];
  assign csr_lane3_wr = wr_take && sel_csr && BYTEENABLE[3];
  assign mask_wr = wr_take && sel_mask && BYTEENABLE[0];
  assign filter_wr = wr_take && sel_filter;
  // any port access steps, whatever its lanes
  assign filter_step = take && sel_filter;

  // pointer reset strobe: bit 31 is never stored, so it reads back zero
  assign ptr_rst = csr_lane3_wr && WRITEDATA[`WKC_BIT_PTR_RST];

  // filter pointer steps on every read or write of the port and wraps
  always_comb begin
    next_ptr = ptr;
    if (ptr_rst) begin
      next_ptr = `WKC_PTR_FIRST;
    end else if (filter_step) begin
      if (ptr == `WKC_PTR_LAST) begin
        next_ptr = `WKC_PTR_FIRST;
      end else begin
        next_ptr = ptr + 6'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ptr <= `WKC_PTR_FIRST;
    end else begin
      ptr <= next_ptr;
    end
  end

  // read address follows next_ptr so the stored word is current one cycle later
  wkc_filter_mem u_filter_mem (
    .clk(CLK),
    .wr_en(filter_wr),
    .wr_be(BYTEENABLE),
    .wr_addr(ptr),
    .wr_data(WRITEDATA),
    .rd_addr(next_ptr),
    .rd_data(filter_rd_data)
  );

  // enable bits, byte lane 0
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      enables <= `WKC_RST_ENABLES;
    end else if (csr_lane0_wr) begin
      enables <= WRITEDATA[`WKC_LSB_EN +: 4];
    end
  end

  // global unicast qualifier, byte lane 1
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      global_unicast_wake_qualifier <= 1'b0;
    end else if (csr_lane1_wr) begin
      global_unicast_wake_qualifier <= WRITEDATA[`WKC_BIT_GUE];
    end
  end

  // sleep gate, byte lane 1
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      wait_sleep <= 1'b0;
    end else if (csr_lane1_wr) begin
      wait_sleep <= WRITEDATA[`WKC_BIT_WAIT_SLEEP];
    end
  end

  // interrupt mask, same layout as the seen flags
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      mask <= `WKC_RST_MASK;
    end else if (mask_wr) begin
      mask <= WRITEDATA[`WKC_LSB_SEEN +: 4];
    end
  end

  // frame classification
  assign active = !wait_sleep || SLEEP_STATE;
  assign global_unicast = !RX_DEST_ADDR_BIT0;
  assign filter_hit = RX_FILTER_MATCH || (global_unicast_wake_qualifier && global_unicast);

  always_comb begin
    hit = 4'h0;
    if (RX_FRAME_VALID && active) begin
      hit[3] = RX_OWN_ADDR_MATCH;
      hit[2] = filter_hit;
      hit[1] = RX_MAGIC_MATCH;
      hit[0] = RX_BROADCAST;
    end
  end

  // write one to clear, lane 0 carries bits 7..4
  assign flag_clear = csr_lane0_wr ? WRITEDATA[`WKC_LSB_SEEN +: 4] : 4'h0;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_flag
      wkc_sticky_flag u_flag (
        .clk(CLK),
        .rstn(RSTN),
        .set(hit[i]),
        .clear(flag_clear[i]),
        .flag(flags[i])
      );
    end
  endgenerate

  // wake needs the matching enable; the unicast qualifier rides on bit 2
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      WAKE_REQUEST <= 1'b0;
    end else begin
      WAKE_REQUEST <= |(hit & enables);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      DETECT_ACTIVE <= 1'b0;
    end else begin
      DETECT_ACTIVE <= active;
    end
  end

  // level interrupt from registered state, one cycle behind the flags
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(flags & mask);
    end
  end

  // reserved bits and the strobe bit read as zero
  always_comb begin
    csr_view = 32'h0000_0000;
    csr_view[`WKC_BIT_GUE] = global_unicast_wake_qualifier;
    csr_view[`WKC_BIT_WAIT_SLEEP] = wait_sleep;
    csr_view[`WKC_LSB_SEEN +: 4] = flags;
    csr_view[`WKC_LSB_EN +: 4] = enables;
  end

  // mask image; spare bits read as zero
  always_comb begin
    mask_view = 32'h0000_0000;
    mask_view[`WKC_LSB_SEEN +: 4] = mask;
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel_filter) begin
      next_readdata = filter_rd_data;
    end else if (sel_csr) begin
      next_readdata = csr_view;
    end else if (sel_mask) begin
      next_readdata = mask_view;
    end
  end

  // captured while waitrequest is still high, stands during the answer cycle
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      READDATA <= 32'h0000_0000;
    end else if (bus_state == BUS_IDLE && READ) begin
      READDATA <= next_readdata;
    end else if (rd_take) begin
      READDATA <= READDATA;
    end
  end
endmodule : wkc_wake_csr

// *** pkg/wkc_defines.svh ***
`ifndef WKC_DEFINES_SVH
`define WKC_DEFINES_SVH

// register indices; byte address is four times the index
`define WKC_IDX_FILTER_PORT 6'h0b
`define WKC_IDX_WAKE_CSR 6'h0c
`define WKC_IDX_IRQ_MASK 6'h10

// wake control and status fields
`define WKC_BIT_PTR_RST 31
`define WKC_BIT_GUE 9
`define WKC_BIT_WAIT_SLEEP 8
`define WKC_LSB_SEEN 4
`define WKC_LSB_EN 0

// reset values
`define WKC_RST_ENABLES 4'h0
`define WKC_RST_FLAGS 4'h0
`define WKC_RST_MASK 4'h0

// filter storage
`define WKC_FILTER_DEPTH 40
`define WKC_PTR_LAST 6'h27
`define WKC_PTR_FIRST 6'h00

`endif

// *** pkg/wkc_pkg.sv ***
package wkc_pkg;
  // event order: [3] own address, [2] filter, [1] magic pattern, [0] broadcast
  typedef logic [3:0] wkc_evt_t;
  typedef logic [5:0] wkc_ptr_t;
  typedef logic [31:0] wkc_word_t;
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } wkc_bus_state_t;
endpackage : wkc_pkg

// *** hw/wkc_sticky_flag.sv ***
`timescale 1ns/100ps
module wkc_sticky_flag (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic set,
  input wire logic clear,
  // state
  output logic flag
);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule : wkc_sticky_flag

// *** hw/wkc_filter_mem.sv ***
`timescale 1ns/100ps
`include "wkc_defines.svh"
module wkc_filter_mem
  import wkc_pkg::*;
(
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [3:0] wr_be,
  input wire wkc_ptr_t wr_addr,
  input wire wkc_word_t wr_data,
  // read side, data registered
  input wire wkc_ptr_t rd_addr,
  output wkc_word_t rd_data
);
  // no reset on the array; contents are undefined until software loads them
  // one array per byte lane so no array has two writing processes
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      logic [7:0] mem [0:`WKC_FILTER_DEPTH-1];
      always_ff @(posedge clk) begin
        if (wr_en && wr_be[lane]) begin
          mem[wr_addr] <= wr_data[lane*8 +: 8];
        end
        rd_data[lane*8 +: 8] <= mem[rd_addr];
      end
    end
  endgenerate
endmodule : wkc_filter_mem

// *** sim/wkc_wake_csr_asserts.sv ***
`timescale 1ns/100ps
module wkc_wake_csr_asserts (
  // bus
  input wire logic CLK, RSTN, READ, WRITE, WAITREQUEST,
  input wire logic [7:0] ADDRESS,
  input wire logic [31:0] READDATA,
  // frames and outputs
  input wire logic RX_FRAME_VALID, RX_DEST_ADDR_BIT0, RX_BROADCAST, RX_MAGIC_MATCH,
  input wire logic RX_FILTER_MATCH, RX_OWN_ADDR_MATCH, SLEEP_STATE, WAKE_REQUEST, DETECT_ACTIVE, IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic rd;
  assign rd = READ && !WAITREQUEST;
  chk_wait_one: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("answer longer than one cycle");
  chk_wait_bound: assert property ((READ || WRITE) |-> ##[0:1] !WAITREQUEST)
    else $error("no answer in time");
  chk_hole_zero: assert property (rd && ADDRESS == 8'h00 |-> READDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_csr_reserved: assert property (rd && ADDRESS == 8'h30 |-> READDATA[31:10] == 22'h0)
    else $error("csr upper bits not zero");
  chk_mask_spare: assert property (rd && ADDRESS == 8'h40 |-> {READDATA[31:8], READDATA[3:0]} == 28'h0)
    else $error("mask spare bits set");
  chk_wake_cause: assert property (WAKE_REQUEST |-> $past(RX_FRAME_VALID))
    else $error("wake without frame");
  chk_wake_hit: assert property (WAKE_REQUEST |-> $past(RX_BROADCAST || RX_MAGIC_MATCH ||
    RX_FILTER_MATCH || RX_OWN_ADDR_MATCH || !RX_DEST_ADDR_BIT0)) else $error("wake without hit");
  chk_sleep_detect: assert property (SLEEP_STATE |=> DETECT_ACTIVE)
    else $error("asleep but detection off");
  // reach of the main scenarios
  cover property (WAKE_REQUEST);
  cover property ($rose(IRQ));
  cover property (WRITE && !WAITREQUEST);
endmodule : wkc_wake_csr_asserts
bind wkc_wake_csr wkc_wake_csr_asserts chk_i (.*);

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import wkc_pkg::*;
  logic CLK, RSTN, READ, WRITE, RX_FRAME_VALID, SLEEP_STATE, pv, lp;
  logic RX_DEST_ADDR_BIT0, RX_OWN_ADDR_MATCH, RX_FILTER_MATCH, RX_MAGIC_MATCH, RX_BROADCAST;
  logic [7:0] ADDRESS;
  logic [3:0] BYTEENABLE;
  logic [4:0] cls;
  logic [15:0] lf = 16'heb2e;
  wkc_word_t WRITEDATA, READDATA, w[40], q[$];
  logic WAITREQUEST, WAKE_REQUEST, DETECT_ACTIVE, IRQ, wq[$];
  logic [1:0] lq[$];
  int miscompares, check_count, i;
  assign {RX_DEST_ADDR_BIT0, RX_OWN_ADDR_MATCH, RX_FILTER_MATCH, RX_MAGIC_MATCH, RX_BROADCAST} = cls;
  wkc_wake_csr uut (
    .CLK(CLK),
    .RSTN(RSTN),
    .ADDRESS(ADDRESS),
    .READ(READ),
    .WRITE(WRITE),
    .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE),
    .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST),
    .RX_FRAME_VALID(RX_FRAME_VALID),
    .RX_DEST_ADDR_BIT0(RX_DEST_ADDR_BIT0),
    .RX_BROADCAST(RX_BROADCAST),
    .RX_MAGIC_MATCH(RX_MAGIC_MATCH),
    .RX_FILTER_MATCH(RX_FILTER_MATCH),
    .RX_OWN_ADDR_MATCH(RX_OWN_ADDR_MATCH),
    .SLEEP_STATE(SLEEP_STATE),
    .WAKE_REQUEST(WAKE_REQUEST),
    .DETECT_ACTIVE(DETECT_ACTIVE),
    .IRQ(IRQ)
  );
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  function automatic logic [15:0] lfsr_next();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : lfsr_next
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // holds the request until waitrequest is seen low
  task bus(input logic r, input logic [7:0] a, input wkc_word_t d, input logic [3:0] be);
    int n;
    @(posedge CLK);
    READ <= r;
    WRITE <= !r;
    ADDRESS <= a;
    WRITEDATA <= d;
    BYTEENABLE <= be;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    READ <= 0;
    WRITE <= 0;
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
  endtask : bus
  task wr(input logic [7:0] a, input wkc_word_t d, input logic [3:0] be);
    bus(0, a, d, be);
  endtask : wr
  task rd(input logic [7:0] a, input wkc_word_t e);
    q.push_back(e);
    bus(1, a, {lfsr_next(), lfsr_next()}, 4'hf);
  endtask : rd
  // qualifiers turn to junk outside the frame pulse
  task fr(input logic [4:0] c, input logic wk);
    wq.push_back(wk);
    @(posedge CLK);
    cls <= c;
    RX_FRAME_VALID <= 1;
    @(posedge CLK);
    RX_FRAME_VALID <= 0;
    cls <= 5'(lfsr_next());
  endtask : fr
  // level outputs {detect, irq} noted, looked at one edge later
  task lvl(input logic [1:0] e);
    lq.push_back(e);
    lp <= 1'b1;
    @(posedge CLK);
    lp <= 1'b0;
  endtask : lvl
  always @(posedge CLK) begin
    if (READ && WAITREQUEST === 1'b0) chk(READDATA, q.pop_front());
    if (pv) chk({31'h0, WAKE_REQUEST}, {31'h0, wq.pop_front()});
    if (lp) chk({30'h0, DETECT_ACTIVE, IRQ}, {30'h0, lq.pop_front()});
    pv <= RX_FRAME_VALID;
  end
  initial begin
    {RSTN, READ, WRITE, RX_FRAME_VALID, SLEEP_STATE, lp} = 6'h0;
    {ADDRESS, WRITEDATA, BYTEENABLE, cls} = '0;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge CLK);
    RSTN <= 1;
    rd(8'h30, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'hffffffff, 4'hf);
    rd(8'h00, 32'h0);
    // one enable at a time; the next source must not wake
    for (i = 0; i < 4; i++) begin
      wr(8'h30, 32'hf0 | (32'h1 << i), 4'h1);
      fr(5'(32'h10 | (32'h1 << i)), 1);
      fr(5'(32'h10 | (32'h1 << ((i + 1) % 4))), 0);
      rd(8'h30, (32'h1 << i) | (32'h10 << i) | (32'h10 << ((i + 1) % 4)));
    end
    wr(8'h30, 32'h1f1, 4'h3);
    fr(5'h11, 0);
    lvl(2'b00);
    SLEEP_STATE <= 1;
    fr(5'h11, 1);
    rd(8'h30, 32'h111);
    lvl(2'b10);
    SLEEP_STATE <= 0;
    wr(8'h30, 32'h2f0, 4'h3);
    fr(5'h00, 0);
    rd(8'h30, 32'h240);
    wr(8'h30, 32'h2f4, 4'h3);
    fr(5'h00, 1);
    fr(5'h10, 0);
    rd(8'h30, 32'h244);
    wr(8'h40, 32'h10, 4'h1);
    rd(8'h40, 32'h10);
    lvl(2'b10);
    fr(5'h11, 0);
    // frame lands on the clearing edge
    fork
      wr(8'h30, 32'h50, 4'h1);
      begin
        @(posedge CLK);
        fr(5'h11, 0);
      end
    join
    rd(8'h30, 32'h210);
    lvl(2'b11);
    wr(8'h30, 32'h10, 4'h1);
    rd(8'h40, 32'h10);
    lvl(2'b10);
    for (i = 0; i < 40; i++) begin
      w[i] = {lfsr_next(), lfsr_next()};
      wr(8'h2c, w[i], 4'hf);
    end
    for (i = 0; i < 41; i++) rd(8'h2c, w[i % 40]);
    // reserved lanes written with ones must still read zero
    wr(8'h30, 32'hffff0000, 4'hc);
    rd(8'h2c, w[0]);
    rd(8'h30, 32'h200);
    // mid-run reset clears the fields and sends the pointer home
    RSTN <= 0;
    repeat (3) @(posedge CLK);
    RSTN <= 1;
    rd(8'h30, 32'h0);
    rd(8'h2c, w[0]);
    @(posedge CLK);
    if (q.size() != 0 || wq.size() != 0 || lq.size() != 0) begin
      miscompares++;
    end
    stop_test();
  end
endmodule : tb_top
